// >>> core/config_memory_crc_monitor.sv
/*
 * Background CRC-32 checker over configuration memory, with error flag,
 * open-drain flag pin, serial signature readout port and Wishbone registers.
 * Assumes configuration memory answers mem_data_i for mem_addr_o in the same
 * cycle, and that user_clk_i is synchronous to clk_i.
 */
`timescale 1ns/1ps
`default_nettype none

module config_memory_crc_monitor #(
   parameter int              MEM_WORDS    = 64,
   parameter logic            CHECK_EN_RST = 1'b1,
   parameter logic [3:0]      DIV_EXP_RST  = 4'h0
) (
   // Clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   // Wishbone slave
   input  wire crc_mon_pkg::wb_req_s wb_i,
   output var  crc_mon_pkg::wb_rsp_s wb_o,
   // Configuration status
   input  wire logic                 user_mode_i,
   input  wire logic [31:0]          stored_crc_i,
   // Configuration memory read port
   output logic [$clog2(MEM_WORDS)-1:0] mem_addr_o,
   input  wire logic [31:0]          mem_data_i,
   // Error flag and its open-drain pin
   output logic                      crc_error_o,
   output logic                      err_pin_o,
   output logic                      err_pin_oe_o,
   // User serial readout port
   input  wire logic                 user_clk_i,
   input  wire logic                 shift_sel_i,
   input  wire logic                 load_src_i,
   output logic                      read_bit_o
);
   import crc_mon_pkg::*;

   localparam int AW = $clog2(MEM_WORDS);
   localparam logic [AW-1:0] LAST_ADDR = AW'(MEM_WORDS - 1);

   // ---------------------------------------------------------------
   // CRC step over one 32-bit word, MSB first
   // ---------------------------------------------------------------
   function automatic logic [31:0] crc32_word(input logic [31:0] c_in,
                                              input logic [31:0] d);
      logic [31:0] c;
      logic        fb;
      c = c_in;
      for (int i = 31; i >= 0; i--) begin
         fb = c[31] ^ d[i];
         c  = {c[30:0], 1'b0} ^ (fb ? CRC_POLY : 32'h0000_0000);
      end
      return c;
   endfunction : crc32_word

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   mon_state_e          state_reg;
   logic                en_reg;
   logic [EXP_W-1:0]    exp_cfg_reg;
   logic [EXP_W-1:0]    exp_reg;
   logic [DIV_W-1:0]    div_cnt_reg;
   logic [DIV_W-1:0]    div_limit;
   logic                tick;
   logic [AW-1:0]       addr_reg;
   logic [31:0]         crc_reg;
   logic [31:0]         crc_next;
   logic                pass_end;
   logic [31:0]         pre_reg;
   logic [31:0]         sig_reg;
   logic                flag_reg;
   logic [PASS_CNT_W-1:0] pass_cnt_reg;
   logic                ucl_q;
   logic                ucl_rise;
   logic [31:0]         shift_reg;
   logic                ack_reg;
   logic                err_reg;
   logic [DATA_W-1:0]   rdat_reg;
   logic                req;
   logic                hit;
   logic [DATA_W-1:0]   rdat_next;
   logic [EXP_W-1:0]    exp_clamp;

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   // Exponents above the legal range are clamped so the divider never wraps.
   assign exp_clamp = (exp_cfg_reg > EXP_MAX) ? EXP_MAX : exp_cfg_reg;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= ST_IDLE;
         exp_reg   <= DIV_EXP_RST;
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               if (user_mode_i && en_reg) begin
                  state_reg <= ST_RUN;
                  exp_reg   <= exp_clamp;
               end
            end
            ST_RUN: begin
               state_reg <= ST_RUN;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Check-rate divider
   // ---------------------------------------------------------------
   // clk_i stands in for the configuration oscillator; tick is its 2^n divide.
   assign div_limit = DIV_W'((9'h001 << exp_reg) - 9'h001);
   assign tick      = (state_reg == ST_RUN) && (div_cnt_reg == div_limit);

   always_ff @(posedge clk_i) begin
      if (rst_i || state_reg != ST_RUN || tick) begin
         div_cnt_reg <= '0;
      end else begin
         div_cnt_reg <= div_cnt_reg + 8'h01;
      end
   end

   // ---------------------------------------------------------------
   // CRC engine: one word per tick, one pass per memory sweep
   // ---------------------------------------------------------------
   assign crc_next   = crc32_word(crc_reg, mem_data_i);
   assign pass_end   = tick && (addr_reg == LAST_ADDR);
   assign mem_addr_o = addr_reg;

   always_ff @(posedge clk_i) begin
      if (rst_i || state_reg != ST_RUN) begin
         addr_reg <= '0;
         crc_reg  <= CRC_SEED;
      end else if (pass_end) begin
         addr_reg <= '0;
         crc_reg  <= CRC_SEED;
      end else if (tick) begin
         addr_reg <= addr_reg + AW'(1);
         crc_reg  <= crc_next;
      end
   end

   // Stored CRC is captured once, as checking starts in user mode.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pre_reg <= 32'h0000_0000;
      end else if (state_reg == ST_IDLE && user_mode_i && en_reg) begin
         pre_reg <= stored_crc_i;
      end
   end

   // ---------------------------------------------------------------
   // Signature and flag
   // ---------------------------------------------------------------
   // The flag is built from the same pass result as the signature register, never from the
   // user readout or bus logic, so corrupted user logic cannot mask it.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sig_reg      <= 32'h0000_0000;
         flag_reg     <= 1'b0;
         pass_cnt_reg <= '0;
      end else if (pass_end) begin
         sig_reg      <= crc_next ^ pre_reg;
         flag_reg     <= |(crc_next ^ pre_reg);
         pass_cnt_reg <= pass_cnt_reg + PASS_CNT_W'(1);
      end
   end

   // Open-drain pin pulls low while enabled checking runs with the flag clear, released otherwise.
   assign crc_error_o  = flag_reg && en_reg;
   assign err_pin_o    = 1'b0;
   assign err_pin_oe_o = en_reg && (state_reg == ST_RUN) && !flag_reg;

   // ---------------------------------------------------------------
   // User serial readout
   // ---------------------------------------------------------------
   // A load happens on every low-select rise and takes the source select of that
   // same cycle, so one rise is enough before shifting; the reader model gives two.
   assign ucl_rise   = user_clk_i && !ucl_q;
   assign read_bit_o = shift_reg[0];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ucl_q     <= 1'b0;
         shift_reg <= 32'h0000_0000;
      end else begin
         ucl_q <= user_clk_i;
         if (ucl_rise) begin
            if (shift_sel_i) begin
               shift_reg <= {1'b0, shift_reg[31:1]};
            end else begin
               shift_reg <= load_src_i ? sig_reg : pre_reg;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Wishbone slave
   // ---------------------------------------------------------------
   assign req = wb_i.cyc && wb_i.stb && !ack_reg && !err_reg;
   assign hit = (wb_i.adr == OFS_CTRL) || (wb_i.adr == OFS_STATUS) ||
                (wb_i.adr == OFS_SIG)  || (wb_i.adr == OFS_PRE);

   always_comb begin
      rdat_next = '0;
      unique case (wb_i.adr)
         OFS_CTRL: begin
            rdat_next[CTRL_EN_BIT]                     = en_reg;
            rdat_next[CTRL_EXP_LSB +: EXP_W]           = exp_cfg_reg;
         end
         OFS_STATUS: begin
            rdat_next[ST_FLAG_BIT]                     = flag_reg;
            rdat_next[ST_RUN_BIT]                      = state_reg == ST_RUN;
            rdat_next[ST_CNT_LSB +: PASS_CNT_W]        = pass_cnt_reg;
         end
         OFS_SIG:  rdat_next = sig_reg;
         OFS_PRE:  rdat_next = pre_reg;
         default:  rdat_next = '0;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg  <= 1'b0;
         err_reg  <= 1'b0;
         rdat_reg <= '0;
      end else begin
         ack_reg  <= req && hit;
         err_reg  <= req && !hit;
         rdat_reg <= (req && hit && !wb_i.we) ? rdat_next : '0;
      end
   end

   // Settings only take effect when checking starts, so writes once it runs are inert.
   // The write lands at the edge where the master samples ack, not before.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         en_reg      <= CHECK_EN_RST;
         exp_cfg_reg <= DIV_EXP_RST;
      end else if (wb_i.cyc && wb_i.stb && ack_reg && wb_i.we && wb_i.sel[0] &&
                   wb_i.adr == OFS_CTRL && state_reg == ST_IDLE) begin
         en_reg      <= wb_i.dat[CTRL_EN_BIT];
         exp_cfg_reg <= wb_i.dat[CTRL_EXP_LSB +: EXP_W];
      end
   end

   assign wb_o.ack = ack_reg;
   assign wb_o.err = err_reg;
   assign wb_o.dat = rdat_reg;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   AST_START: assert property (
      state_reg == ST_IDLE && user_mode_i && en_reg |=> state_reg == ST_RUN)
      else $error("checking did not start on user mode entry");
   AST_FLAG_LOW_IDLE: assert property (
      state_reg == ST_IDLE |-> !flag_reg)
      else $error("flag raised before any pass");
   AST_FLAG_HOLD: assert property (
      state_reg == ST_RUN && !pass_end |=> $stable(flag_reg))
      else $error("flag changed during a pass");
   AST_FLAG_CLEAN: assert property (
      pass_end && crc_next == pre_reg |=> !flag_reg && sig_reg == 32'h0)
      else $error("clean pass left flag high");
   AST_RUN_STAYS: assert property (
      state_reg == ST_RUN |=> state_reg == ST_RUN)
      else $error("checking stopped without reset");
   AST_TICK_SPACING: assert property (
      tick && exp_reg == 4'h1 |=> !tick ##1 tick)
      else $error("divide by two tick spacing wrong");
   AST_DIV_RANGE: assert property (
      state_reg == ST_RUN |-> exp_reg <= EXP_MAX)
      else $error("divide exponent out of range");
   AST_PASS_END: assert property (
      pass_end |=> addr_reg == '0 && crc_reg == CRC_SEED)
      else $error("pass did not restart from first word");
   AST_FLAG_SIG: assert property (
      flag_reg == (|sig_reg))
      else $error("flag disagrees with signature");
   AST_SHIFT: assert property (
      ucl_rise && shift_sel_i |=> shift_reg == ($past(shift_reg) >> 1))
      else $error("shift step wrong");
   AST_LOAD: assert property (
      ucl_rise && !shift_sel_i && load_src_i |=> shift_reg == $past(sig_reg))
      else $error("signature load wrong");
   AST_PIN_OFF: assert property (
      !en_reg |-> !err_pin_oe_o && !crc_error_o)
      else $error("flag driven while disabled");
   AST_EXP_STATIC: assert property (
      state_reg == ST_RUN |=> $stable(exp_reg))
      else $error("exponent changed while running");
   AST_BUS_ACK: assert property (
      req |=> (ack_reg ^ err_reg) ##1 !ack_reg && !err_reg)
      else $error("bus answer not one cycle");
   AST_FLAG_RISE: assert property (
      $rose(flag_reg) |-> $past(pass_end))
      else $error("flag rose without a finished pass");
   AST_PASS_COUNT: assert property (
      pass_end |=> pass_cnt_reg == $past(pass_cnt_reg) + PASS_CNT_W'(1))
      else $error("pass count did not advance");
   AST_ADDR_HOLD: assert property (
      state_reg == ST_RUN && !tick |=> $stable(addr_reg))
      else $error("word address moved between ticks");
   AST_SHIFT_HOLD: assert property (
      !ucl_rise |=> $stable(shift_reg))
      else $error("readout register moved without a user clock rise");
   AST_LOAD_PRE: assert property (
      ucl_rise && !shift_sel_i && !load_src_i |=> shift_reg == $past(pre_reg))
      else $error("stored value load wrong");
   AST_CFG_FROZEN: assert property (
      state_reg == ST_RUN |=> $stable(exp_cfg_reg) && $stable(en_reg))
      else $error("settings changed while running");

   COV_PASS_ERR: cover property (pass_end && crc_next != pre_reg);
   COV_RECOVER:  cover property (flag_reg && pass_end && crc_next == pre_reg);
   COV_READOUT:  cover property (ucl_rise && !shift_sel_i ##[1:40] ucl_rise && shift_sel_i);
   COV_UNMAPPED: cover property (err_reg);
   COV_HALF_RATE: cover property (tick && exp_reg == 4'h1);

endmodule : config_memory_crc_monitor

`default_nettype wire

// >>> core/crc_mon_pkg.sv
/*
 * Shared constants and carrier types for the configuration memory CRC monitor.
 * Assumes a classic Wishbone master with a 32-bit data bus and byte addresses.
 */
package crc_mon_pkg;

   // ---------------------------------------------------------------
   // Bus geometry
   // ---------------------------------------------------------------
   localparam int DATA_W = 32;
   localparam int ADR_W  = 8;
   localparam int SEL_W  = 4;

   // ---------------------------------------------------------------
   // Register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [ADR_W-1:0] OFS_CTRL   = 8'h00;
   localparam logic [ADR_W-1:0] OFS_STATUS = 8'h04;
   localparam logic [ADR_W-1:0] OFS_SIG    = 8'h08;
   localparam logic [ADR_W-1:0] OFS_PRE    = 8'h0C;

   // ---------------------------------------------------------------
   // Field layout
   // ---------------------------------------------------------------
   localparam int          CTRL_EN_BIT  = 0;
   localparam int          CTRL_EXP_LSB = 4;
   localparam int          EXP_W        = 4;
   localparam logic [3:0]  EXP_MAX      = 4'h8;
   localparam int          DIV_W        = 8;
   localparam int          ST_FLAG_BIT  = 0;
   localparam int          ST_RUN_BIT   = 1;
   localparam int          ST_CNT_LSB   = 16;
   localparam int          PASS_CNT_W   = 16;

   // ---------------------------------------------------------------
   // CRC engine
   // ---------------------------------------------------------------
   localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
   localparam logic [31:0] CRC_SEED = 32'hFFFFFFFF;

   typedef enum logic {ST_IDLE, ST_RUN} mon_state_e;

   typedef struct packed {
      logic              cyc;
      logic              stb;
      logic              we;
      logic [ADR_W-1:0]  adr;
      logic [SEL_W-1:0]  sel;
      logic [DATA_W-1:0] dat;
   } wb_req_s;

   typedef struct packed {
      logic              ack;
      logic              err;
      logic [DATA_W-1:0] dat;
   } wb_rsp_s;

endpackage : crc_mon_pkg

// >>> verification/config_memory_crc_monitor_tb.sv
/*
 * Self-checking bench for the CRC monitor, four-word memory model.
 * Assumes the design package and the user_reader model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module config_memory_crc_monitor_tb;
   import crc_mon_pkg::*;
   logic        clk, rst, user_mode, crc_err, pin, pin_oe, uclk, ssel, lsrc, rbit;
   logic        bus_err;
   wb_req_s     wb_req;
   wb_rsp_s     wb_rsp;
   logic [31:0] stored, rd;
   logic [1:0]  mem_addr;
   logic [31:0] mem [4];
   int          err_count;
   int          n_compared;

   config_memory_crc_monitor #(.MEM_WORDS(4)) u_dut (
      .clk_i(clk), .rst_i(rst), .wb_i(wb_req), .wb_o(wb_rsp),
      .user_mode_i(user_mode), .stored_crc_i(stored),
      .mem_addr_o(mem_addr), .mem_data_i(mem[mem_addr]),
      .crc_error_o(crc_err), .err_pin_o(pin), .err_pin_oe_o(pin_oe),
      .user_clk_i(uclk), .shift_sel_i(ssel), .load_src_i(lsrc), .read_bit_o(rbit));

   user_reader u_user (.clk_i(clk), .user_clk_o(uclk), .shift_sel_o(ssel),
      .load_src_o(lsrc), .read_bit_i(rbit));

   always #20 clk = ~clk;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : check

   task automatic give_verdict();
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict

   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
      int t;
      @(posedge clk);
      wb_req <= '{1'b1, 1'b1, we, adr, 4'hF, wd};
      t = 0;
      do begin
         @(posedge clk);
         t++;
      end while (wb_rsp.ack !== 1'b1 && wb_rsp.err !== 1'b1 && t < 50);
      rd = wb_rsp.dat;
      bus_err = wb_rsp.err;
      wb_req <= '0;
      check("bus answer", 32'(t < 50), 32'h1);
   endtask : wb

   task automatic do_reset();
      @(posedge clk);
      rst <= 1'b1;
      user_mode <= 1'b0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
   endtask : do_reset

   function automatic logic [31:0] crc_of();
      logic [31:0] c;
      c = CRC_SEED;
      for (int w = 0; w < 4; w++) begin
         for (int b = 31; b >= 0; b--) begin
            c = {c[30:0], 1'b0} ^ ((c[31] ^ mem[w][b]) ? CRC_POLY : 32'h0);
         end
      end
      return c;
   endfunction : crc_of

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_regs();
      do_reset();
      wb(1'b0, OFS_CTRL, 32'h0);
      check("ctrl reset", rd, 32'h00000001);
      wb(1'b0, 8'h10, 32'h0);
      check("unmapped err", 32'(bus_err), 32'h1);
      wb(1'b1, OFS_CTRL, 32'h91);
      wb(1'b0, OFS_CTRL, 32'h0);
      check("exponent field", rd, 32'h00000091);
      wb(1'b0, OFS_STATUS, 32'h0);
      check("idle status", rd, 32'h0);
   endtask : t_regs

   task automatic t_rate(input logic [31:0] ctrl, input logic [31:0] rb, input int period);
      int n;
      logic [1:0] a;
      do_reset();
      wb(1'b1, OFS_CTRL, ctrl);
      @(posedge clk);
      user_mode <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         @(posedge clk);
         a = mem_addr;
         n = 1;
         while (mem_addr === a && n < 1000) begin
            @(posedge clk);
            n++;
         end
      end
      check("tick period", 32'(n), 32'(period));
      wb(1'b1, OFS_CTRL, 32'h1);
      wb(1'b0, OFS_CTRL, 32'h0);
      check("ctrl held", rd, rb);
   endtask : t_rate

   task automatic t_flow();
      logic [31:0] sig, w, cnt;
      int n;
      do_reset();
      @(posedge clk);
      user_mode <= 1'b1;
      wb(1'b0, OFS_STATUS, 32'h0);
      check("running", 32'(rd[1]), 32'h1);
      repeat (20) @(posedge clk);
      check("flag clean", 32'(crc_err), 32'h0);
      wb(1'b0, OFS_SIG, 32'h0);
      check("clean sig", rd, 32'h0);
      cnt = rd;
      wb(1'b0, OFS_STATUS, 32'h0);
      cnt = {16'h0, rd[31:16]};
      repeat (20) @(posedge clk);
      wb(1'b0, OFS_STATUS, 32'h0);
      check("passes advance", 32'(rd[31:16] != cnt[15:0]), 32'h1);
      mem[2][8] <= ~mem[2][8];
      @(posedge clk);
      sig = crc_of() ^ stored;
      repeat (20) @(posedge clk);
      check("flag set", 32'(crc_err), 32'h1);
      check("pin released", 32'(pin_oe), 32'h0);
      check("pin data", 32'(pin), 32'h0);
      wb(1'b0, OFS_SIG, 32'h0);
      check("signature", rd, sig);
      u_user.read_word(1'b1, w);
      check("shifted sig", w, sig);
      u_user.read_word(1'b0, w);
      check("shifted stored", w, stored);
      mem[2][8] <= ~mem[2][8];
      n = 0;
      while (crc_err === 1'b1 && n < 40) begin
         @(posedge clk);
         n++;
      end
      // Flag must stay up until a pass that reads the restored word ends, then drop
      check("flag fall delay", 32'(n >= 3 && n <= 6), 32'h1);
      check("pin pulled", 32'(pin_oe), 32'h1);
   endtask : t_flow

   task automatic t_off();
      do_reset();
      wb(1'b1, OFS_CTRL, 32'h0);
      mem[0][0] <= ~mem[0][0];
      @(posedge clk);
      user_mode <= 1'b1;
      repeat (40) @(posedge clk);
      check("flag off", 32'(crc_err), 32'h0);
      check("pin off", 32'(pin_oe), 32'h0);
      wb(1'b0, OFS_STATUS, 32'h0);
      check("not running", 32'(rd[1]), 32'h0);
      mem[0][0] <= ~mem[0][0];
   endtask : t_off

   // ---------------------------------------------------------------
   // Main sequence and watchdog
   // ---------------------------------------------------------------
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      user_mode = 1'b0;
      wb_req = '0;
      err_count = 0;
      n_compared = 0;
      mem = '{32'h01234567, 32'h89ABCDEF, 32'h0F1E2D3C, 32'hA5A55A5A};
      stored = crc_of();
      t_regs();
      t_rate(32'h91, 32'h91, 256);
      t_rate(32'h31, 32'h31, 8);
      t_rate(32'h11, 32'h11, 2);
      t_flow();
      t_off();
      give_verdict();
   end

   initial begin
      repeat (50000) @(posedge clk);
      err_count++;
      give_verdict();
   end
endmodule : config_memory_crc_monitor_tb

`default_nettype wire

// >>> verification/user_reader.sv
/*
 * User-side readout model: loads and shifts out the signature port.
 * Assumes the monitor samples the user clock as data on clk_i.
 */
`timescale 1ns/1ps
`default_nettype none

module user_reader (
   // Clock
   input  wire logic clk_i,
   // Readout port
   output logic      user_clk_o,
   output logic      shift_sel_o,
   output logic      load_src_o,
   input  wire logic read_bit_i
);
   // ---------------------------------------------------------------
   // Readout; soft-error decisions rest on the flag, not on this
   // ---------------------------------------------------------------
   initial begin
      user_clk_o  = 1'b0;
      shift_sel_o = 1'b0;
      load_src_o  = 1'b0;
   end

   // Each half lasts at least two clk cycles so the sampled rise is never missed
   task automatic rise();
      @(posedge clk_i);
      user_clk_o <= 1'b1;
      repeat (2) @(posedge clk_i);
      user_clk_o <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask : rise

   task automatic read_word(input logic src, output logic [31:0] w);
      @(posedge clk_i);
      shift_sel_o <= 1'b0;
      load_src_o  <= src;
      rise();
      rise();
      w[0] = read_bit_i;
      @(posedge clk_i);
      shift_sel_o <= 1'b1;
      for (int i = 1; i < 32; i++) begin
         rise();
         w[i] = read_bit_i;
      end
      shift_sel_o <= 1'b0;
   endtask : read_word
endmodule : user_reader

`default_nettype wire
